// ---- hw/nprc_pkg.sv ----
package nprc_pkg;
  // clock of the sequencer
  localparam int CLK_NS = 40;
  // busy limits of the flash as printed
  localparam int T_ARRAY_US = 25;       // array_to_register_time
  localparam int T_RD_CACHE_US = 25;    // read_cache_busy
  localparam int T_COPY_CACHE_US = 30;  // copy_cache_busy
  localparam int T_WC_SHORT_US = 10;    // write_cache_busy_short
  localparam int T_WC_LONG_US = 700;    // write_cache_busy_long
  localparam int T_PROG_MAX_US = 700;
  localparam int T_ERASE_MS = 5;        // block_erase_time
  localparam int T_WB_NS = 100;         // write strobe high to busy
  // longest times round down, least times round up
  localparam logic [16:0] ARRAY_CYC = 17'(T_ARRAY_US * 1000 / CLK_NS);
  localparam logic [16:0] RD_CACHE_CYC = 17'(T_RD_CACHE_US * 1000 / CLK_NS);
  localparam logic [16:0] COPY_CACHE_CYC = 17'(T_COPY_CACHE_US * 1000 / CLK_NS);
  localparam logic [16:0] WC_SHORT_CYC = 17'(T_WC_SHORT_US * 1000 / CLK_NS);
  localparam logic [16:0] WC_LONG_CYC = 17'(T_WC_LONG_US * 1000 / CLK_NS);
  localparam logic [16:0] PROG_MAX_CYC = 17'(T_PROG_MAX_US * 1000 / CLK_NS);
  localparam logic [16:0] ERASE_MAX_CYC = 17'(T_ERASE_MS * 1000000 / CLK_NS);
  localparam logic [16:0] WB_CYC = 17'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] SYNC_CYC = 17'h00002;
  localparam logic [16:0] SETTLE_CYC = WB_CYC + SYNC_CYC;
  localparam logic [16:0] RD_LOW_CYC = 17'h00004;
  // address bytes and program limits
  localparam logic [2:0] ADDR_LAST = 3'h4;
  localparam int ROW_LSB = 16;
  localparam logic [2:0] PART_PROG_MAX = 3'h4;
  localparam int STATUS_READY_BIT = 6;    // status_ready_bit
  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONF = 8'h30;
  localparam logic [7:0] CMD_CACHE_RD = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
  localparam logic [7:0] CMD_COPY_CONF = 8'h3a;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_MULTI_SETUP = 8'h81;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
  localparam logic [7:0] CMD_COPY_PROG = 8'h8c;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] CMD_PROG_CONT = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // user request kinds
  typedef enum logic [1:0] {
    K_CMD = 2'b00,
    K_ADDR = 2'b01,
    K_WR = 2'b10,
    K_RD = 2'b11
  } nprc_kind_t;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_STROBE = 3'b010,
    S_HOLD = 3'b011,
    S_TAIL = 3'b100,
    S_READ = 3'b101,
    S_SETTLE = 3'b110,
    S_WAIT = 3'b111
  } nprc_state_t;
endpackage

// ---- hw/nprc_sync.sv ----
module nprc_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // two flops per bit, first read only by second
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg[g] <= 1'b0;
          q_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_d[g];
          q_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign o_q = q_reg;
endmodule // nprc_sync

// ---- hw/nprc_host.sv ----
// What this block does
// - at most 4 partial programs in a row to one page; a program to another page or any erase restarts the count
// - cache read sequence ends with 3Fh
// - single-plane cache program ends with 80h-10h
// - after 80h-15h poll status, then reset
// - multi-page cache program ends with 81h-10h
// - after 81h-15h poll status, then reset
// - never drive port while flash outputs
// - command bytes written with command latch high
// - address is five address latch cycles
module nprc_host import nprc_pkg::*; #(
  parameter logic [16:0] PROG_LIMIT_CYC = PROG_MAX_CYC,
  parameter logic [16:0] WC_LIMIT_CYC = WC_LONG_CYC,
  parameter logic [16:0] ERASE_LIMIT_CYC = ERASE_MAX_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_kind,
  input wire logic [7:0] i_req_byte,
  input wire logic [39:0] i_req_addr,
  input wire logic [7:0] i_io_in,
  input wire logic i_ready_busy_n,
  output logic o_req_ready,
  output logic o_done,
  output logic o_refused,
  output logic o_timeout,
  output logic [7:0] o_rd_data,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic o_wp_n,
  output logic [7:0] o_io_out,
  output logic o_io_oe_n
);
  logic rst_n;
  logic [7:0] io_sync;
  logic rb_sync;
  nprc_state_t state_reg;
  nprc_kind_t kind_reg;
  logic [7:0] byte_reg;
  logic [39:0] addr_reg;
  logic [2:0] idx_reg;
  logic [16:0] cnt_reg;
  logic [16:0] limit_reg;
  logic cache_rd_open_reg;
  logic cache_pg_open_reg;
  logic status_ok_reg;
  logic [7:0] last_cmd_reg;
  logic [23:0] last_row_reg;
  logic [23:0] prog_row_reg;
  logic [2:0] pg_count_reg;
  logic refuse;
  logic accept;
  logic rd_capture;
  logic is_confirm;

  // busy bound for each command that starts an operation
  function automatic logic [16:0] busy_limit(input logic [7:0] c);
    case (c)
      CMD_READ_CONF: busy_limit = ARRAY_CYC;
      CMD_CACHE_RD, CMD_CACHE_LAST: busy_limit = RD_CACHE_CYC;
      CMD_COPY_CONF: busy_limit = COPY_CACHE_CYC;
      CMD_PROG_CONT: busy_limit = WC_SHORT_CYC;
      CMD_PROG_CACHE: busy_limit = WC_LIMIT_CYC;
      CMD_PROG_CONF: busy_limit = PROG_LIMIT_CYC;
      CMD_ERASE_CONF: busy_limit = ERASE_LIMIT_CYC;
      CMD_RESET: busy_limit = PROG_LIMIT_CYC;
      default: busy_limit = 17'h00000;
    endcase
  endfunction

  // reset release through two flops
  nprc_sync #(.W(1)) u_rst_sync (
    .i_clock(i_clock),
    .i_rst_n(i_arst_n),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  // pins from the flash
  nprc_sync #(.W(9)) u_sync (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_d({i_ready_busy_n, i_io_in}),
    .o_q({rb_sync, io_sync})
  );

  // sequence checks on a new request
  assign is_confirm = i_req_byte inside {CMD_PROG_CONF, CMD_PROG_CONT, CMD_PROG_CACHE};
  always_comb begin
    refuse = 1'b0;
    if (i_req_kind == K_CMD) begin
      if (cache_rd_open_reg && !(i_req_byte inside {CMD_CACHE_RD, CMD_CACHE_LAST, CMD_STATUS,
          CMD_STATUS_MULTI, CMD_RESET})) refuse = 1'b1;
      if (cache_pg_open_reg && !(i_req_byte inside {CMD_PROG_SETUP, CMD_MULTI_SETUP, CMD_COL_CHANGE,
          CMD_COPY_PROG, CMD_PROG_CONF, CMD_PROG_CONT, CMD_PROG_CACHE, CMD_STATUS, CMD_STATUS_MULTI,
          CMD_RESET})) refuse = 1'b1;
      if (i_req_byte == CMD_RESET && cache_pg_open_reg && !status_ok_reg) refuse = 1'b1;
      if (is_confirm && last_row_reg == prog_row_reg && pg_count_reg == PART_PROG_MAX)
        refuse = 1'b1;
    end
  end
  assign accept = (state_reg == S_IDLE) && i_req_valid && !refuse;
  assign rd_capture = (state_reg == S_READ) && (cnt_reg == RD_LOW_CYC - 17'h00001);

  // pin sequencer
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      kind_reg <= K_CMD;
      byte_reg <= 8'h00;
      addr_reg <= 40'h0000000000;
      idx_reg <= 3'h0;
      cnt_reg <= 17'h00000;
      limit_reg <= 17'h00000;
      o_req_ready <= 1'b1;
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_timeout <= 1'b0;
      o_rd_data <= 8'h00;
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_wp_n <= 1'b1;
      o_io_out <= 8'h00;
      o_io_oe_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_timeout <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (i_req_valid && refuse) begin
            o_refused <= 1'b1;
          end else if (accept) begin
            kind_reg <= nprc_kind_t'(i_req_kind);
            byte_reg <= i_req_byte;
            addr_reg <= i_req_addr;
            idx_reg <= 3'h0;
            cnt_reg <= 17'h00000;
            limit_reg <= (i_req_kind == K_CMD) ? busy_limit(i_req_byte) : 17'h00000;
            o_req_ready <= 1'b0;
            o_ce_n <= 1'b0;
            state_reg <= (i_req_kind == K_RD) ? S_READ : S_SETUP;
          end
        end
        S_SETUP: begin
          o_cle <= (kind_reg == K_CMD);
          o_ale <= (kind_reg == K_ADDR);
          o_io_out <= (kind_reg == K_ADDR) ? addr_reg[7:0] : byte_reg;
          o_io_oe_n <= 1'b0;
          state_reg <= S_STROBE;
        end
        S_STROBE: begin
          o_we_n <= 1'b0;
          state_reg <= S_HOLD;
        end
        S_HOLD: begin
          o_we_n <= 1'b1; // byte latched on this rising edge
          state_reg <= S_TAIL;
        end
        S_TAIL: begin
          o_cle <= 1'b0;
          o_ale <= 1'b0;
          o_io_oe_n <= 1'b1; // release port before any read
          if (kind_reg == K_ADDR && idx_reg != ADDR_LAST) begin
            idx_reg <= idx_reg + 3'h1;
            addr_reg <= {8'h00, addr_reg[39:8]};
            state_reg <= S_SETUP;
          end else if (limit_reg != 17'h00000) begin
            cnt_reg <= 17'h00000;
            state_reg <= S_SETTLE;
          end else begin
            o_done <= 1'b1;
            o_req_ready <= 1'b1;
            o_ce_n <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_READ: begin
          o_read_strobe_n <= 1'b0;
          cnt_reg <= cnt_reg + 17'h00001;
          if (rd_capture) begin
            o_rd_data <= io_sync;
            o_read_strobe_n <= 1'b1;
            o_done <= 1'b1;
            o_req_ready <= 1'b1;
            o_ce_n <= 1'b1; // ends output drive in either strobe mode
            state_reg <= S_IDLE;
          end
        end
        S_SETTLE: begin
          cnt_reg <= cnt_reg + 17'h00001;
          if (cnt_reg == SETTLE_CYC - 17'h00001) begin
            cnt_reg <= 17'h00000;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_reg <= cnt_reg + 17'h00001;
          if (rb_sync || cnt_reg == limit_reg) begin
            o_timeout <= !rb_sync;
            o_done <= 1'b1;
            o_req_ready <= 1'b1;
            o_ce_n <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // sequence tracking for cache reads, cache programs and partial programs
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cache_rd_open_reg <= 1'b0;
      cache_pg_open_reg <= 1'b0;
      status_ok_reg <= 1'b0;
      last_cmd_reg <= 8'h00;
      last_row_reg <= 24'h000000;
      prog_row_reg <= 24'h000000;
      pg_count_reg <= 3'h0;
    end else begin
      if (accept && i_req_kind == K_ADDR) last_row_reg <= i_req_addr[ROW_LSB +: 24];
      if (accept && i_req_kind == K_CMD) begin
        last_cmd_reg <= i_req_byte;
        if (i_req_byte == CMD_CACHE_RD) begin
          cache_rd_open_reg <= 1'b1;
        end else if (i_req_byte == CMD_CACHE_LAST || i_req_byte == CMD_RESET) begin
          cache_rd_open_reg <= 1'b0;
        end
        if (i_req_byte == CMD_PROG_CACHE) begin
          cache_pg_open_reg <= 1'b1;
          status_ok_reg <= 1'b0;
        end else if (i_req_byte == CMD_PROG_CONF || i_req_byte == CMD_RESET) begin
          cache_pg_open_reg <= 1'b0;
        end
        if (is_confirm) begin
          prog_row_reg <= last_row_reg;
          pg_count_reg <= (last_row_reg == prog_row_reg) ? pg_count_reg + 3'h1 : 3'h1;
        end else if (i_req_byte == CMD_ERASE_CONF) begin
          pg_count_reg <= 3'h0;
        end
      end
      if (rd_capture && (last_cmd_reg == CMD_STATUS || last_cmd_reg == CMD_STATUS_MULTI) &&
          io_sync[STATUS_READY_BIT]) status_ok_reg <= 1'b1;
    end
  end

  a_cmd_latch: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_STROBE && kind_reg == K_CMD) |=> (!o_we_n && o_cle && !o_ale) ##1 (o_we_n && o_cle))
    else $error("command strobe without command latch");
  a_no_clash: assert property (@(posedge i_clock) disable iff (!rst_n)
    !o_read_strobe_n |-> o_io_oe_n) else $error("port driven during read");
  a_addr_five: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_TAIL && kind_reg == K_ADDR) |=> (state_reg == S_SETUP) == ($past(idx_reg) != ADDR_LAST))
    else $error("address cycle count wrong");
  a_cache_rd_end: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_IDLE && i_req_valid && i_req_kind == K_CMD && cache_rd_open_reg &&
     i_req_byte == CMD_READ_SETUP) |=> (o_refused && state_reg == S_IDLE))
    else $error("read accepted inside cache read");
  a_cache_pg_end: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_IDLE && i_req_valid && i_req_kind == K_CMD && cache_pg_open_reg &&
     i_req_byte == CMD_ERASE_SETUP) |=> o_refused) else $error("erase accepted inside cache program");
  a_reset_gate: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_IDLE && i_req_valid && i_req_kind == K_CMD && i_req_byte == CMD_RESET &&
     cache_pg_open_reg && !status_ok_reg) |=> (o_refused && cache_pg_open_reg))
    else $error("reset before status poll");
  a_part_prog: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_IDLE && i_req_valid && i_req_kind == K_CMD && i_req_byte == CMD_PROG_CONF &&
     last_row_reg == prog_row_reg && pg_count_reg == PART_PROG_MAX) |=> o_refused)
    else $error("fifth partial program accepted");
  a_busy_bound: assert property (@(posedge i_clock) disable iff (!rst_n)
    (state_reg == S_WAIT && !rb_sync && cnt_reg == limit_reg) |=> (o_timeout && o_done && o_req_ready))
    else $error("busy limit not enforced");
  a_erase_limit: assert property (@(posedge i_clock) disable iff (!rst_n)
    (accept && i_req_kind == K_CMD && i_req_byte == CMD_ERASE_CONF) |=> limit_reg == ERASE_LIMIT_CYC)
    else $error("erase limit wrong");
  a_cache_limit: assert property (@(posedge i_clock) disable iff (!rst_n)
    (accept && i_req_kind == K_CMD && i_req_byte == CMD_CACHE_LAST) |=> limit_reg == RD_CACHE_CYC)
    else $error("cache read limit wrong");
endmodule // nprc_host

// ---- verification/nprc_flash_model.sv ----
module nprc_flash_model (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_slow,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_io_en,
  output logic o_ready_busy_n,
  output logic [7:0] o_last_cmd,
  output logic [39:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] addr_cnt;
  logic [15:0] col_reg;
  logic status_mode;
  initial begin
    o_io = 8'h00;
    o_io_en = 1'b0;
    o_ready_busy_n = 1'b1;
    o_last_cmd = 8'h00;
    o_addr = 40'h0;
    addr_cnt = 3'h0;
    col_reg = 16'h0000;
    status_mode = 1'b0;
  end
  // busy pulse on the open-drain pin; slow mode overruns the host limit
  task automatic go_busy(input int ns);
    #40 o_ready_busy_n = 1'b0;
    #(i_slow ? 30000 : ns) o_ready_busy_n = 1'b1;
  endtask
  // command and address capture on write strobe rise
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      o_last_cmd = i_io;
      addr_cnt = 3'h0;
      status_mode = (i_io == 8'h70) || (i_io == 8'h71);
      case (i_io)
        8'h30: go_busy(600);
        8'h31, 8'h3f: go_busy(600);
        8'h3a: go_busy(800);
        8'h11: go_busy(200);
        8'h15: go_busy(800);
        8'h10: go_busy(1000);
        8'hd0: go_busy(1200);
        8'hff: go_busy(200);
        default: ;
      endcase
    end else if (!i_ce_n && i_ale) begin
      o_addr[{addr_cnt, 3'b000} +: 8] = i_io;
      col_reg = o_addr[15:0];
      addr_cnt = addr_cnt + 3'h1;
    end
  end
  // next byte on each read strobe fall, column steps by one except in status mode
  always @(negedge i_read_strobe_n) begin
    if (!i_ce_n) begin
      o_io = status_mode ? {1'b0, o_ready_busy_n, 6'h00} : (col_reg[7:0] ^ 8'h5a);
      if (!status_mode) col_reg = col_reg + 16'h0001;
      o_io_en = 1'b1;
    end
  end
  // short strobe high keeps driving until a latch, enable or write edge
  always @(posedge i_ce_n or posedge i_cle or posedge i_ale or negedge i_we_n) o_io_en = 1'b0;
  // long strobe high turns the outputs off
  always @(posedge i_read_strobe_n) begin
    #60;
    if (i_read_strobe_n) o_io_en = 1'b0;
  end
endmodule // nprc_flash_model

// ---- verification/tb.sv ----
module tb;
  import nprc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'b00;
  logic [7:0] req_byte = 8'h00;
  logic [39:0] req_addr = 40'h0;
  logic slow = 1'b0;
  logic busy_seen = 1'b0;
  logic [7:0] last_io = 8'h00;
  logic [7:0] d;
  wire req_ready, done, refused, tmo, ce_n, cle, ale, we_n, rs_n, wp_n, io_oe_n, fl_en, rb_n;
  wire [7:0] rd_data, io_out, fl_io, last_cmd, io_in;
  wire [39:0] fl_addr;
  int error_cnt = 0;
  int checked = 0;
  int clash = 0;
  localparam logic [39:0] A_RD = 40'h0102030034;
  always #20 i_clock = ~i_clock;
  // port level: host drive, flash drive, else a changing pattern
  assign io_in = !io_oe_n ? io_out : (fl_en ? fl_io : ~last_io);
  always @(posedge i_clock) begin
    last_io <= io_in;
    if (!io_oe_n && fl_en) clash <= clash + 1;
  end
  always @(negedge rb_n) busy_seen = 1'b1;
  nprc_host #(.PROG_LIMIT_CYC(17'h00032), .WC_LIMIT_CYC(17'h00032), .ERASE_LIMIT_CYC(17'h00032)) DUT (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_req_valid(req_valid), .i_req_kind(req_kind),
    .i_req_byte(req_byte), .i_req_addr(req_addr), .i_io_in(io_in), .i_ready_busy_n(rb_n),
    .o_req_ready(req_ready), .o_done(done), .o_refused(refused), .o_timeout(tmo), .o_rd_data(rd_data),
    .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(rs_n), .o_wp_n(wp_n),
    .o_io_out(io_out), .o_io_oe_n(io_oe_n));
  nprc_flash_model flash (
    .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_read_strobe_n(rs_n), .i_slow(slow),
    .i_io(io_in), .o_io(fl_io), .o_io_en(fl_en), .o_ready_busy_n(rb_n), .o_last_cmd(last_cmd),
    .o_addr(fl_addr));
  task automatic test_done();
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, held for one clock, then bounded wait for done unless refused
  task automatic req(input logic [1:0] k, input logic [7:0] b, input logic [39:0] a, input logic r, input logic t);
    int n;
    logic got_ref;
    logic got_tmo;
    got_tmo = 1'b0;
    @(negedge i_clock);
    req_valid = 1'b1;
    req_kind = k;
    req_byte = b;
    req_addr = a;
    @(negedge i_clock);
    got_ref = refused;
    req_valid = 1'b0;
    if (got_ref !== 1'b1) begin
      for (n = 0; n < 1000 && done !== 1'b1; n++) @(negedge i_clock);
      got_tmo = tmo;
      chk(done, 1'b1);
    end
    chk(got_ref, r);
    chk(got_tmo, t);
  endtask
  task automatic cmd(input logic [7:0] b, input logic r);
    req(K_CMD, b, 40'h0, r, 1'b0);
  endtask
  task automatic adr(input logic [39:0] a);
    req(K_ADDR, 8'h00, a, 1'b0, 1'b0);
    chk(fl_addr, a);
  endtask
  task automatic rd(output logic [7:0] v);
    req(K_RD, 8'h00, 40'h0, 1'b0, 1'b0);
    v = rd_data;
  endtask
  task automatic prog(input logic [7:0] s, input logic [39:0] a, input logic [7:0] c, input logic r);
    cmd(s, 1'b0);
    adr(a);
    req(K_WR, 8'h3c, 40'h0, 1'b0, 1'b0);
    cmd(c, r);
  endtask
  task automatic t_page_read();
    cmd(CMD_READ_SETUP, 1'b0);
    chk(last_cmd, 8'h00);
    adr(A_RD);
    busy_seen = 1'b0;
    cmd(CMD_READ_CONF, 1'b0);
    chk(last_cmd, CMD_READ_CONF);
    chk(busy_seen, 1'b1);
    chk(rb_n, 1'b1);
    rd(d);
    chk(d, 8'h34 ^ 8'h5a);
    rd(d);
    chk(d, 8'h35 ^ 8'h5a);
    chk(fl_en, 1'b0);
  endtask
  task automatic t_cache_read();
    cmd(CMD_CACHE_RD, 1'b0);
    cmd(CMD_PROG_SETUP, 1'b1);
    cmd(CMD_READ_SETUP, 1'b1);
    cmd(CMD_STATUS, 1'b0);
    rd(d);
    chk(d[6], 1'b1);
    cmd(CMD_CACHE_LAST, 1'b0);
    cmd(CMD_READ_SETUP, 1'b0);
    adr(A_RD);
    cmd(CMD_COPY_CONF, 1'b0);
  endtask
  task automatic t_cache_prog();
    prog(CMD_PROG_SETUP, 40'h0000100000, CMD_PROG_CACHE, 1'b0);
    cmd(CMD_READ_SETUP, 1'b1);
    cmd(CMD_ERASE_SETUP, 1'b1);
    prog(CMD_PROG_SETUP, 40'h0000110000, CMD_PROG_CONT, 1'b0);
    prog(CMD_MULTI_SETUP, 40'h0000120000, CMD_PROG_CACHE, 1'b0);
    prog(CMD_MULTI_SETUP, 40'h0000130000, CMD_PROG_CONF, 1'b0);
    cmd(CMD_READ_SETUP, 1'b0);
    prog(CMD_PROG_SETUP, 40'h0000140000, CMD_PROG_CACHE, 1'b0);
    cmd(CMD_RESET, 1'b1);
    cmd(CMD_STATUS, 1'b0);
    rd(d);
    chk(d[6], 1'b1);
    cmd(CMD_RESET, 1'b0);
  endtask
  task automatic t_partial();
    repeat (4) prog(CMD_PROG_SETUP, 40'h0000200000, CMD_PROG_CONF, 1'b0);
    prog(CMD_PROG_SETUP, 40'h0000200000, CMD_PROG_CONF, 1'b1);
    cmd(CMD_ERASE_SETUP, 1'b0);
    adr(40'h0000200000);
    cmd(CMD_ERASE_CONF, 1'b0);
    prog(CMD_PROG_SETUP, 40'h0000200000, CMD_PROG_CONF, 1'b0);
  endtask
  // flash held busy past the limit must end with a timeout pulse
  task automatic t_timeout();
    slow = 1'b1;
    cmd(CMD_READ_SETUP, 1'b0);
    adr(A_RD);
    req(K_CMD, CMD_READ_CONF, 40'h0, 1'b0, 1'b1);
    #5000;
    slow = 1'b0;
  endtask
  initial begin
    repeat (4) @(negedge i_clock);
    chk(req_ready, 1'b1);
    chk(ce_n, 1'b1);
    chk(io_oe_n, 1'b1);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    chk(wp_n, 1'b1);
    chk(we_n, 1'b1);
    t_page_read();
    t_cache_read();
    t_cache_prog();
    t_partial();
    t_timeout();
    chk(clash, 0);
    test_done();
  end
  // watchdog well beyond the expected run
  initial begin
    #600000;
    error_cnt++;
    test_done();
  end
endmodule // tb
